// ===== cac_defs.vh
// Constants for the channel asymmetry compensation controller.
`ifndef CAC_DEFS_VH
`define CAC_DEFS_VH
`define CAC_NCH 2
`define CAC_NTERM 3
`define CAC_DW 16
`define CAC_RTT_THR_MAX 16'h0064
`define CAC_RTT_THR_RESET 16'h000F
`define CAC_ASYM_THR_RESET 16'h0000
`define CAC_RTT_THR_STEP_US 100
`define CAC_ADDR_W 4
`define CAC_REG_CTRL 4'h0
`define CAC_REG_ASYM_THR 4'h1
`define CAC_REG_RTT_THR 4'h2
`define CAC_REG_STATUS 4'h3
`define CAC_REG_IRQ_STAT 4'h4
`define CAC_REG_IRQ_MASK 4'h5
`define CAC_REG_CORR1 4'h6
`define CAC_REG_CORR2 4'h7
`define CAC_ST_ACTIVE 0
`define CAC_ST_MEMO 1
`define CAC_ST_VALID 2
`define CAC_ST_ASYM1 3
`define CAC_ST_ASYM2 4
`define CAC_ST_RTT1 5
`define CAC_ST_RTT2 6
`endif

// ===== cac_ctrl.v
// Channel asymmetry compensation controller with Avalon-MM register slave.
`timescale 1ns/1ps
`include "cac_defs.vh"
module cac_ctrl (
  // Clock and reset.
  input wire core_clk_i,
  input wire reset_i,
  // Compensation control.
  input wire asym_comp_enable_i,
  input wire time_ref_block_i,
  input wire [`CAC_NTERM-1:0] time_code_fail_i,
  // Channel measurements, one sample per strobe.
  input wire [`CAC_NCH-1:0] meas_valid_i,
  input wire [`CAC_NCH*`CAC_DW-1:0] asym_meas_i,
  input wire [`CAC_NCH*`CAC_DW-1:0] rtt_meas_i,
  // Correction outputs.
  output reg comp_active_o,
  output reg [`CAC_NCH*`CAC_DW-1:0] corr_o,
  output reg ch1_asym_high_o,
  output reg ch2_asym_high_o,
  output reg ch1_rtt_change_o,
  output reg ch2_rtt_change_o,
  // Avalon-MM slave.
  input wire [`CAC_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Settings and state.
  reg [`CAC_DW-1:0] asym_thr;
  reg [`CAC_DW-1:0] rtt_thr;
  reg [3:0] irq_stat;
  reg [3:0] irq_mask;
  reg comp_memo;
  reg acc_done;

  // Next values.
  reg next_comp_memo;
  reg next_comp_active;
  reg [`CAC_DW-1:0] next_asym_thr;
  reg [`CAC_DW-1:0] next_rtt_thr;
  reg [3:0] next_irq_mask;
  reg [3:0] next_irq_stat;
  reg [31:0] next_readdata;

  // Combinational nets.
  wire [`CAC_NTERM-1:0] term_ok;
  wire all_ok;
  wire ch1_ends_ok;
  wire ch2_ends_ok;
  wire [`CAC_DW-1:0] corr_ch1;
  wire [`CAC_DW-1:0] corr_ch2;
  wire [`CAC_NCH-1:0] asym_flag;
  wire [`CAC_NCH-1:0] rtt_flag;
  wire [3:0] flag_vec;
  wire [3:0] flag_prev;
  wire [3:0] flag_rise;
  wire [`CAC_DW-1:0] wdata_lo;
  wire rtt_thr_ok;
  wire acc_start;
  wire wr_take;
  wire rd_take;
  wire [31:0] status_word;

  // Terminal 0 is local and is also gated by the block input.
  assign term_ok[0] = ~time_ref_block_i & ~time_code_fail_i[0];
  assign term_ok[`CAC_NTERM-1:1] = ~time_code_fail_i[`CAC_NTERM-1:1];
  assign all_ok = &term_ok;
  // Channel n joins the local terminal with remote terminal n.
  assign ch1_ends_ok = term_ok[0] & term_ok[1];
  assign ch2_ends_ok = term_ok[0] & term_ok[2];

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel measurement, correction memory and checks against the shared thresholds.
  cac_chan #(
    .DW(`CAC_DW)
  ) ch1_u (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .meas_valid_i(meas_valid_i[0]),
    .ends_ok_i(ch1_ends_ok),
    .asym_i(asym_meas_i[`CAC_DW-1:0]),
    .rtt_i(rtt_meas_i[`CAC_DW-1:0]),
    .asym_thr_i(asym_thr),
    .rtt_thr_i(rtt_thr),
    .corr_o(corr_ch1),
    .asym_flag_o(asym_flag[0]),
    .rtt_flag_o(rtt_flag[0])
  );

  cac_chan #(
    .DW(`CAC_DW)
  ) ch2_u (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .meas_valid_i(meas_valid_i[1]),
    .ends_ok_i(ch2_ends_ok),
    .asym_i(asym_meas_i[2*`CAC_DW-1:`CAC_DW]),
    .rtt_i(rtt_meas_i[2*`CAC_DW-1:`CAC_DW]),
    .asym_thr_i(asym_thr),
    .rtt_thr_i(rtt_thr),
    .corr_o(corr_ch2),
    .asym_flag_o(asym_flag[1]),
    .rtt_flag_o(rtt_flag[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compensation mode: valid references with the enable on set the memory, and the memory keeps correction on.
  // The memory is dropped as soon as the enable falls, so a later loss of the
  // reference with the enable back on starts from no correction at all.
  always @* begin
    next_comp_memo = comp_memo;
    next_comp_active = comp_active_o;
    if (!asym_comp_enable_i) begin
      next_comp_memo = 1'b0;
      next_comp_active = 1'b0;
    end else if (all_ok) begin
      next_comp_memo = 1'b1;
      next_comp_active = 1'b1;
    end else begin
      next_comp_active = comp_memo;
    end
  end

  // Every output is a registered copy, so the mode follows its inputs by one edge.
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      comp_memo <= 1'b0;
      comp_active_o <= 1'b0;
      corr_o <= 32'h00000000;
      ch1_asym_high_o <= 1'b0;
      ch2_asym_high_o <= 1'b0;
      ch1_rtt_change_o <= 1'b0;
      ch2_rtt_change_o <= 1'b0;
    end else begin
      comp_memo <= next_comp_memo;
      comp_active_o <= next_comp_active;
      corr_o <= {corr_ch2, corr_ch1};
      ch1_asym_high_o <= asym_flag[0];
      ch2_asym_high_o <= asym_flag[1];
      ch1_rtt_change_o <= rtt_flag[0];
      ch2_rtt_change_o <= rtt_flag[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register slave: a request is taken on its first edge and answered on the next.
  // The done bit keeps a held request from being taken twice.
  assign acc_start = (avs_read | avs_write) & ~acc_done;
  assign wr_take = avs_write & ~acc_done;
  assign rd_take = avs_read & ~acc_done;
  assign wdata_lo = avs_writedata[`CAC_DW-1:0];
  // A round-trip threshold beyond 10 ms is refused and the old one kept.
  assign rtt_thr_ok = (wdata_lo <= `CAC_RTT_THR_MAX);
  assign flag_vec = {rtt_flag, asym_flag};
  // The registered flag outputs hold last cycle's flags, so this is a rising edge.
  assign flag_prev = {ch2_rtt_change_o, ch1_rtt_change_o, ch2_asym_high_o, ch1_asym_high_o};
  assign flag_rise = flag_vec & ~flag_prev;
  assign status_word = {25'h0, ch2_rtt_change_o, ch1_rtt_change_o,
                        ch2_asym_high_o, ch1_asym_high_o,
                        all_ok, comp_memo, comp_active_o};

  // Write decode for the settings.
  always @* begin
    next_asym_thr = asym_thr;
    next_rtt_thr = rtt_thr;
    next_irq_mask = irq_mask;
    if (wr_take) begin
      case (avs_address)
        `CAC_REG_ASYM_THR: begin
          next_asym_thr = wdata_lo;
        end
        `CAC_REG_RTT_THR: begin
          if (rtt_thr_ok) begin
            next_rtt_thr = wdata_lo;
          end
        end
        `CAC_REG_IRQ_MASK: begin
          next_irq_mask = avs_writedata[3:0];
        end
        default: begin
          next_asym_thr = asym_thr;
        end
      endcase
    end
  end

  // New flag rises win over a same-cycle clear.
  always @* begin
    next_irq_stat = irq_stat | flag_rise;
    if (wr_take && avs_address == `CAC_REG_IRQ_STAT) begin
      next_irq_stat = (irq_stat & ~avs_writedata[3:0]) | flag_rise;
    end
  end

  // Read mux; unmapped addresses read as zero.
  always @* begin
    case (avs_address)
      `CAC_REG_CTRL: next_readdata = {31'h0, asym_comp_enable_i};
      `CAC_REG_ASYM_THR: next_readdata = {16'h0000, asym_thr};
      `CAC_REG_RTT_THR: next_readdata = {16'h0000, rtt_thr};
      `CAC_REG_STATUS: next_readdata = status_word;
      `CAC_REG_IRQ_STAT: next_readdata = {28'h0, irq_stat};
      `CAC_REG_IRQ_MASK: next_readdata = {28'h0, irq_mask};
      `CAC_REG_CORR1: next_readdata = {16'h0000, corr_ch1};
      `CAC_REG_CORR2: next_readdata = {16'h0000, corr_ch2};
      default: next_readdata = 32'h00000000;
    endcase
  end

  // Read data is loaded only when a read is taken and then holds until the next one.
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      asym_thr <= `CAC_ASYM_THR_RESET;
      rtt_thr <= `CAC_RTT_THR_RESET;
      irq_mask <= 4'h0;
      irq_stat <= 4'h0;
      acc_done <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      irq_o <= 1'b0;
    end else begin
      asym_thr <= next_asym_thr;
      rtt_thr <= next_rtt_thr;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      acc_done <= acc_start;
      avs_waitrequest <= ~acc_start;
      irq_o <= |(irq_stat & irq_mask);
      if (rd_take) begin
        avs_readdata <= next_readdata;
      end
    end
  end

endmodule // cac_ctrl

////////////////////////////////////////////////////////////////////////////
// One channel: correction memory, asymmetry flag and round-trip change flag.
module cac_chan #(
  parameter DW = 16
) (
  // Clock and reset.
  input wire core_clk_i,
  input wire reset_i,
  // Measurement strobe and samples.
  input wire meas_valid_i,
  input wire ends_ok_i,
  input wire [DW-1:0] asym_i,
  input wire [DW-1:0] rtt_i,
  // Shared thresholds.
  input wire [DW-1:0] asym_thr_i,
  input wire [DW-1:0] rtt_thr_i,
  // Channel results.
  output reg [DW-1:0] corr_o,
  output reg asym_flag_o,
  output reg rtt_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Round-trip history.
  reg [DW-1:0] last_rtt;
  reg rtt_seen;

  // Next values.
  reg [DW-1:0] next_corr;
  reg next_asym_flag;
  reg next_rtt_flag;
  reg [DW-1:0] next_last_rtt;
  reg next_rtt_seen;

  // Unsigned distance between this and the previous round-trip sample.
  wire [DW-1:0] rtt_delta;

  // Round-trip samples share the threshold's 0.1 ms unit.
  assign rtt_delta = (rtt_i > last_rtt) ? (rtt_i - last_rtt) : (last_rtt - rtt_i);

  ////////////////////////////////////////////////////////////////////////////
  // The first round-trip sample only seeds the history, so no change is flagged.
  // The correction and the asymmetry flag freeze while either end lacks a reference.
  always @* begin
    next_corr = corr_o;
    next_asym_flag = asym_flag_o;
    next_rtt_flag = rtt_flag_o;
    next_last_rtt = last_rtt;
    next_rtt_seen = rtt_seen;
    if (meas_valid_i) begin
      if (ends_ok_i) begin
        next_corr = asym_i;
        next_asym_flag = (asym_i > asym_thr_i);
      end
      next_rtt_flag = rtt_seen & (rtt_delta > rtt_thr_i);
      next_last_rtt = rtt_i;
      next_rtt_seen = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      corr_o <= {DW{1'b0}};
      asym_flag_o <= 1'b0;
      rtt_flag_o <= 1'b0;
      last_rtt <= {DW{1'b0}};
      rtt_seen <= 1'b0;
    end else begin
      corr_o <= next_corr;
      asym_flag_o <= next_asym_flag;
      rtt_flag_o <= next_rtt_flag;
      last_rtt <= next_last_rtt;
      rtt_seen <= next_rtt_seen;
    end
  end

endmodule // cac_chan

// ===== cac_far_end.sv
// Remote terminal model sending channel measurement strobes.
`timescale 1ns/1ps
module cac_far_end (
  input wire core_clk_i,
  input wire [1:0] send_i,
  input wire [15:0] asym_i,
  input wire [15:0] rtt_i,
  output reg [1:0] strobe_o,
  output reg [31:0] asym_o,
  output reg [31:0] rtt_o
);
  initial begin
    strobe_o = 2'h0;
    asym_o = 32'h0;
    rtt_o = 32'h0;
  end
  // Samples toggle outside strobes so a stale value is never taken for a new one.
  always @(posedge core_clk_i) begin
    strobe_o <= send_i;
    asym_o <= (send_i != 2'h0) ? {2{asym_i}} : ~asym_o;
    rtt_o <= (send_i != 2'h0) ? {2{rtt_i}} : ~rtt_o;
  end
endmodule // cac_far_end

// ===== cac_ctrl_asserts.sv
// Port checker for the asymmetry compensation controller.
`timescale 1ns/1ps
module cac_chk (
  input wire core_clk_i, reset_i, asym_comp_enable_i, time_ref_block_i,
  input wire [2:0] time_code_fail_i,
  input wire [1:0] meas_valid_i,
  input wire [31:0] asym_meas_i, corr_o,
  input wire comp_active_o, ch1_asym_high_o, ch1_rtt_change_o,
  input wire avs_read, avs_write, avs_waitrequest
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  a_off_idle: assert property (!asym_comp_enable_i |=> !comp_active_o)
    else $error("active while off");
  a_valid_on: assert property (asym_comp_enable_i && !time_ref_block_i &&
    time_code_fail_i == 3'h0 |=> comp_active_o) else $error("not active");
  a_no_start: assert property (asym_comp_enable_i && $past(asym_comp_enable_i) &&
    !comp_active_o && time_ref_block_i |=> !comp_active_o) else $error("started blocked");
  a_memo_hold: assert property (asym_comp_enable_i && comp_active_o |=> comp_active_o)
    else $error("memo lost");
  a_corr_freeze: assert property (time_ref_block_i [*2] |=> $stable(corr_o))
    else $error("corr moved");
  a_corr_take: assert property (meas_valid_i[0] && !time_ref_block_i &&
    time_code_fail_i[1:0] == 2'h0 |=> ##1 corr_o[15:0] == $past(asym_meas_i[15:0], 2))
    else $error("corr not taken");
  a_flag_hold: assert property (!meas_valid_i[0] |=> ##1
    $stable({ch1_asym_high_o, ch1_rtt_change_o})) else $error("flag moved");
  a_bus_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("late answer");
endmodule // cac_chk
bind cac_ctrl cac_chk chk_u (.*);

// ===== tb_top.sv
// Self-checking bench for the asymmetry compensation controller.
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, en = 0, blk = 0, rd = 0, wr = 0, act, wq, irq, f1, fr, f2, fr2;
  logic [2:0] fail = 0;
  logic [1:0] send = 0, stb;
  logic [3:0] adr = 0;
  logic [15:0] av = 0, rv = 0, a, r, p;
  logic [31:0] wd = 0, q, am, rm, cor, rdat, seed = 32'h3650;
  int n_fail = 0, checked = 0;
  always #12.5 clk = ~clk;
  cac_far_end far_u (.core_clk_i(clk), .send_i(send), .asym_i(av), .rtt_i(rv),
    .strobe_o(stb), .asym_o(am), .rtt_o(rm));
  cac_ctrl dut_u (.core_clk_i(clk), .reset_i(rst), .asym_comp_enable_i(en),
    .time_ref_block_i(blk), .time_code_fail_i(fail), .meas_valid_i(stb), .asym_meas_i(am),
    .rtt_meas_i(rm), .comp_active_o(act), .corr_o(cor), .ch1_asym_high_o(f1),
    .ch2_asym_high_o(f2), .ch1_rtt_change_o(fr), .ch2_rtt_change_o(fr2), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wq), .irq_o(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic over(input logic [15:0] v, t);
    return v > t;
  endfunction
  task chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= ad;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (wq !== 1'b0) n_fail++;
    q = rdat;
    rd <= 0;
    wr <= 0;
  endtask
  task setm(input logic e, b, input logic [2:0] f);
    @(posedge clk);
    en <= e;
    blk <= b;
    fail <= f;
    @(posedge clk);
    @(negedge clk);
  endtask
  task meas(input logic [1:0] c, input logic [15:0] x, y);
    @(posedge clk);
    send <= c;
    av <= x;
    rv <= y;
    @(posedge clk);
    send <= 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #50us;
    n_fail++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    bus(0, 4'h2, 0);
    chk("rtt_thr", q, 32'hF);
    bus(1, 4'h2, 32'h65);
    bus(0, 4'h2, 0);
    chk("rtt_thr_over", q, 32'hF);
    bus(1, 4'h2, 32'h64);
    bus(0, 4'h2, 0);
    chk("rtt_thr_max", q, 32'h64);
    bus(0, 4'hF, 0);
    chk("unmapped", q, 0);
    bus(1, 4'h2, 32'h5);
    bus(1, 4'h1, 32'h100);
    $display("registers done");
    setm(0, 0, 0);
    chk("off", act, 0);
    setm(1, 1, 0);
    chk("blocked", act, 0);
    setm(1, 0, 3'h4);
    chk("code_fail", act, 0);
    setm(1, 0, 0);
    chk("on", act, 1);
    bus(0, 4'h3, 0);
    chk("status", q, 32'h7);
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      a = (i == 0) ? 16'h100 : (i == 1) ? 16'h101 : {6'h0, seed[9:0]};
      r = {12'h0, seed[19:16]};
      meas(2'h1, a, r);
      chk("corr1", cor[15:0], a);
      chk("asym1", f1, over(a, 16'h100));
      if (i > 0) chk("rtt1", fr, over(r > p ? r - p : p - r, 16'h5));
      p = r;
    end
    meas(2'h2, 16'h2A, 0);
    chk("corr2", cor[31:16], 16'h2A);
    chk("asym2_low", f2, 0);
    chk("rtt2_first", fr2, 0);
    meas(2'h2, 16'h180, 16'h9);
    chk("asym2", f2, 1);
    chk("rtt2", fr2, 1);
    bus(0, 4'h4, 0);
    chk("irq_stat", q[0], 1);
    chk("masked", irq, 0);
    bus(1, 4'h5, 32'h1);
    setm(1, 0, 0);
    chk("irq", irq, 1);
    bus(1, 4'h4, 32'hF);
    setm(1, 0, 3'h4);
    chk("irq_clr", irq, 0);
    chk("memo", act, 1);
    meas(2'h3, 16'h33, 0);
    chk("ch1_only", cor, 32'h01800033);
    chk("asym2_held", f2, 1);
    setm(1, 1, 0);
    meas(2'h1, 16'h44, 0);
    chk("frozen", cor[15:0], 16'h33);
    setm(!(f1 | fr), 1, 0);
    chk("latched", act, !(f1 | fr));
    setm(0, 1, 0);
    chk("off_live", act, 0);
    $display("modes done");
    stop_test;
  end
endmodule // tb_top
